// ### design/asp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - with select low, data input is sampled on each rising serial clock edge until the config byte is complete
// - with select low and the config byte complete, next output bit is shifted out on each falling edge
// - select high: clock and data ignored, data output released
// - internal clock mode: strobe rises when a result is ready to read
// - external clock mode: strobe stays low, never pulses
// - strobe is driven at all times; in internal clock mode a falling select clears it unless a load arrives
// - first one after select falls is start bit, bit 7 of config byte
module asp_top
    import asp_pkg::*;
(
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    input  wire logic                i_sclk,
    input  wire logic                i_cs_n,
    input  wire logic                i_din,
    input  wire logic                i_internal_clk_mode,
    input  wire logic                i_result_load,
    input  wire logic [RES_BITS-1:0] i_result_data,
    output logic                     o_dout,
    output logic                     o_dout_oe,
    output logic                     o_result_ready_strobe,
    output logic [CFG_BITS-1:0]      o_cfg_byte,
    output logic                     o_cfg_valid,
    output logic                     o_result_taken
);
    // link domain, cleared asynchronously while select is high
    asp_rx_state_t         rx_state_q;
    logic [2:0]            rx_cnt_q;
    logic [CFG_BITS-2:0]   rx_sh_q;
    logic [CFG_BITS-1:0]   link_cfg_q;
    logic                  link_done_q;
    logic [4:0]            tx_cnt_q;
    logic                  dout_q;
    logic                  rx_in_cfg;

    // system domain
    logic [RES_BITS-1:0]   result_q;
    logic                  cs_n_sync;
    logic                  done_sync;
    logic                  done_prev_q;
    logic                  cs_prev_q;
    logic                  strobe_q;
    logic                  oe_q;
    logic [CFG_BITS-1:0]   cfg_byte_q;
    logic                  cfg_valid_q;
    logic                  taken_q;
    logic                  load_ok;

    function automatic logic res_bit(input logic [RES_BITS-1:0] w, input logic [4:0] idx);
        logic [4:0] pos;
        pos = 5'(RES_BITS - 1) - idx;
        res_bit = (idx < TX_LAST_CNT) ? w[pos[3:0]] : 1'b0;
    endfunction

    // receive state: hunt for start bit, then seven more config bits
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            rx_state_q <= ASP_RX_HUNT;
        end else begin
            case (rx_state_q)
                ASP_RX_HUNT: begin
                    if (i_din) begin
                        rx_state_q <= ASP_RX_CFG;
                    end
                end
                ASP_RX_CFG: begin
                    if (rx_cnt_q == CFG_LAST_CNT) begin
                        rx_state_q <= ASP_RX_DONE;
                    end
                end
                ASP_RX_DONE: begin
                    rx_state_q <= ASP_RX_DONE;
                end
                default: begin
                    rx_state_q <= ASP_RX_HUNT;
                end
            endcase
        end
    end

    assign rx_in_cfg = (rx_state_q == ASP_RX_CFG);

    // config bit counter, only runs after the start bit
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            rx_cnt_q <= 3'h0;
        end else if (rx_in_cfg) begin
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end else begin
            rx_cnt_q <= 3'h0;
        end
    end

    // config bits shift in msb first behind the start bit
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            rx_sh_q <= '0;
        end else if (rx_in_cfg) begin
            rx_sh_q <= {rx_sh_q[CFG_BITS-3:0], i_din};
        end
    end

    // complete byte and done flag, held until select rises
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            link_cfg_q  <= CFG_RST;
            link_done_q <= 1'b0;
        end else if (rx_in_cfg && (rx_cnt_q == CFG_LAST_CNT)) begin
            link_cfg_q  <= {1'b1, rx_sh_q[CFG_BITS-3:0], i_din};
            link_done_q <= 1'b1;
        end
    end

    // transmit bit counter, stops after the last result bit
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            tx_cnt_q <= 5'h0;
        end else if (link_done_q && (tx_cnt_q != TX_LAST_CNT)) begin
            tx_cnt_q <= tx_cnt_q + 5'h1;
        end
    end

    // transmit: result msb first after the config byte, zeros beyond
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            dout_q <= 1'b0;
        end else if (link_done_q) begin
            dout_q <= res_bit(result_q, tx_cnt_q);
        end
    end

    assign o_dout = dout_q;

    asp_sync2 #(
        .RST_VAL (1'b1)
    ) u_cs_sync (
        .i_clk   (i_mclk),
        .i_rst   (i_rst),
        .i_async (i_cs_n),
        .o_sync  (cs_n_sync)
    );

    asp_sync2 #(
        .RST_VAL (1'b0)
    ) u_done_sync (
        .i_clk   (i_mclk),
        .i_rst   (i_rst),
        .i_async (link_done_q),
        .o_sync  (done_sync)
    );

    // done flag one cycle back, for its rising edge
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            done_prev_q <= 1'b0;
        end else begin
            done_prev_q <= done_sync;
        end
    end

    // select one cycle back; idles high like the pin, so no false edge
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_n_sync;
        end
    end

    // config byte handed over once its level has crossed
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_byte_q  <= CFG_RST;
            cfg_valid_q <= 1'b0;
        end else begin
            cfg_valid_q <= done_sync & ~done_prev_q;
            if (done_sync & ~done_prev_q) begin
                cfg_byte_q <= link_cfg_q;
            end
        end
    end

    // loads accepted only after select has been high for two synced cycles
    assign load_ok = i_result_load & cs_n_sync & cs_prev_q;

    // result word only changes while the link is idle, so it is stable in a frame
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            result_q <= RES_RST;
        end else if (load_ok) begin
            result_q <= i_result_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            taken_q <= 1'b0;
        end else begin
            taken_q <= load_ok;
        end
    end

    // strobe: set by a new result, cleared when a frame starts; load wins
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            strobe_q <= 1'b0;
        end else if (!i_internal_clk_mode) begin
            strobe_q <= 1'b0;
        end else if (taken_q) begin
            strobe_q <= 1'b1;
        end else if (cs_prev_q & ~cs_n_sync) begin
            strobe_q <= 1'b0;
        end
    end

    // output enable follows select after crossing
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ~cs_n_sync;
        end
    end

    assign o_result_ready_strobe = strobe_q;
    assign o_dout_oe             = oe_q;
    assign o_cfg_byte            = cfg_byte_q;
    assign o_cfg_valid           = cfg_valid_q;
    assign o_result_taken        = taken_q;
endmodule

// ### design/asp_pkg.sv
package asp_pkg;
    localparam int          MCLK_PERIOD_NS = 100;
    localparam int          CFG_BITS       = 8;
    localparam int          RES_BITS       = 16;
    localparam int          START_POS      = 7;
    localparam logic [2:0]  CFG_LAST_CNT   = 3'h6;
    localparam logic [4:0]  TX_LAST_CNT    = 5'h10;
    localparam logic [15:0] RES_RST        = 16'h0000;
    localparam logic [7:0]  CFG_RST        = 8'h00;
    localparam logic [1:0]  SYNC_RST       = 2'h0;
    localparam logic [1:0]  SYNC_RST_HIGH  = 2'h3;

    typedef enum logic [1:0] {
        ASP_RX_HUNT = 2'b00,
        ASP_RX_CFG  = 2'b01,
        ASP_RX_DONE = 2'b10
    } asp_rx_state_t;
endpackage

// ### design/asp_sync2.sv
`timescale 1ns/1ps
module asp_sync2
    import asp_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic [1:0] stage_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage_q <= RST_VAL ? SYNC_RST_HIGH : SYNC_RST;
        end else begin
            stage_q <= {stage_q[0], i_async};
        end
    end

    assign o_sync = stage_q[1];
endmodule

// ### tb/asp_top_checker.sv
`timescale 1ns/1ps
module asp_top_checker
    import asp_pkg::*;
(
    input wire logic                i_mclk,
    input wire logic                i_rst,
    input wire logic                i_cs_n,
    input wire logic                i_internal_clk_mode,
    input wire logic                i_result_load,
    input wire logic                o_dout,
    input wire logic                o_dout_oe,
    input wire logic                o_result_ready_strobe,
    input wire logic [CFG_BITS-1:0] o_cfg_byte,
    input wire logic                o_cfg_valid
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    chk_oe_idle_off: assert property (i_cs_n [*4] |-> !o_dout_oe)
        else $error("dout enabled while deselected");
    chk_dout_idle_low: assert property (i_cs_n |-> !o_dout)
        else $error("dout not released");
    chk_oe_frame_on: assert property (!i_cs_n [*4] |-> o_dout_oe)
        else $error("dout not enabled in frame");
    chk_strobe_rise: assert property (i_cs_n [*5] ##0 (i_result_load && i_internal_clk_mode)
        |=> ##1 o_result_ready_strobe)
        else $error("strobe missing after load");
    chk_ext_strobe_low: assert property (!i_internal_clk_mode [*3] |-> !o_result_ready_strobe)
        else $error("strobe high in external mode");
    chk_strobe_held: assert property ($fell(o_result_ready_strobe)
        |-> !$past(i_cs_n, 3) || !$past(i_internal_clk_mode))
        else $error("strobe dropped outside frame start");
    chk_cfg_start_bit: assert property (o_cfg_valid |-> o_cfg_byte[START_POS] && !$past(i_cs_n, 3)
        ##1 !o_cfg_valid)
        else $error("config byte without start bit");
endmodule
bind asp_top asp_top_checker asp_top_checker_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n),
    .i_internal_clk_mode(i_internal_clk_mode), .i_result_load(i_result_load), .o_dout(o_dout),
    .o_dout_oe(o_dout_oe), .o_result_ready_strobe(o_result_ready_strobe),
    .o_cfg_byte(o_cfg_byte), .o_cfg_valid(o_cfg_valid));

// ### tb/asp_host.sv
`timescale 1ns/1ps
module asp_host (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    input  wire logic i_dout
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end
    task automatic pulse();
        #62.5 o_sclk = 1'b1;
        #62.5 o_sclk = 1'b0;
    endtask
    // wiggles clock and data while deselected
    task automatic noise();
        repeat (6) begin
            #31 o_sclk = ~o_sclk;
            o_din = ~o_din;
        end
    endtask
    task automatic frame(input logic [7:0] cfg, input int zeros, output logic [15:0] res);
        logic [7:0] bits;
        bits = cfg;
        #13 o_cs_n = 1'b0;
        #400 o_din = 1'b0;
        repeat (zeros) pulse();
        for (int k = 0; k < 8; k++) begin
            o_din = bits[7];
            bits = bits << 1;
            pulse();
        end
        for (int k = 0; k < 16; k++) begin
            o_din = ~o_din;
            #62.5 res = {res[14:0], i_dout};
            o_sclk = 1'b1;
            #62.5 o_sclk = 1'b0;
        end
        #400 o_cs_n = 1'b1;
        #400;
    endtask
endmodule

// ### tb/asp_top_tb.sv
`timescale 1ns/1ps
module asp_top_tb;
    import asp_pkg::*;
    logic        i_mclk, i_rst, mode, load, sclk, cs_n, din, dout, oe, strobe, cfg_v, taken;
    logic [15:0] rdata, res;
    logic [7:0]  cfg;
    int          error_cnt = 0;
    int          checks_done = 0;
    wire         dout_line = oe ? dout : 1'bz;
    asp_top asp_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
        .i_internal_clk_mode(mode), .i_result_load(load), .i_result_data(rdata), .o_dout(dout),
        .o_dout_oe(oe), .o_result_ready_strobe(strobe), .o_cfg_byte(cfg), .o_cfg_valid(cfg_v),
        .o_result_taken(taken));
    asp_host asp_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout_line));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic put(input logic [15:0] v);
        @(negedge i_mclk);
        rdata = v;
        load = 1'b1;
        @(negedge i_mclk);
        load = 1'b0;
    endtask
    task automatic t_internal();
        mode = 1'b1;
        put(16'ha5c3);
        cmp("taken", 16'h1, taken);
        @(negedge i_mclk);
        cmp("strobe", 16'h1, strobe);
        asp_host_i.noise();
        cmp("strobe held", 16'h1, strobe);
        asp_host_i.frame(8'h9b, 3, res);
        cmp("cfg", 16'h9b, cfg);
        cmp("result", 16'ha5c3, res);
        cmp("strobe cleared", 16'h0, strobe);
    endtask
    task automatic t_external();
        @(negedge i_mclk);
        mode = 1'b0;
        put(16'h1111);
        put(16'h8001);
        repeat (3) @(negedge i_mclk);
        cmp("strobe ext", 16'h0, strobe);
        asp_host_i.frame(8'hc4, 0, res);
        cmp("cfg", 16'hc4, cfg);
        cmp("result", 16'h8001, res);
    endtask
    initial begin
        i_rst = 1'b1;
        mode = 1'b0;
        load = 1'b0;
        rdata = 16'h0000;
        repeat (20) @(negedge i_mclk);
        cmp("oe reset", 16'h0, oe);
        i_rst = 1'b0;
        // a clean select history after reset lets the load checks see the first load
        repeat (4) @(negedge i_mclk);
        t_internal();
        t_external();
        finish_test();
    end
    // both frames need about 9 us
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
endmodule
